/* itx_exec.sv */
// instruction executor for interrupt control and timer transfers
`timescale 1ns/1ps
module itx_exec (
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire itx_pkg::itx_req_t req,
	output itx_pkg::itx_rsp_t    rsp,
	output itx_pkg::itx_ctl_t    ctl,
	output logic                 ext0_flag,
	output logic                 first_timer_flag,
	output logic                 second_timer_flag,
	input  wire logic            ext_pin,
	input  wire logic            ext0_evt,
	input  wire logic            first_timer_evt,
	input  wire logic            second_timer_evt,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic [31:0]          wb_dat_o,
	output logic                 wb_ack_o
);
	import itx_pkg::*;

	itx_state_t st;
	itx_state_t next_st;
	logic       bus_req;
	logic       bus_wr;
	logic       clr_ext0;
	logic       clr_t1;
	logic       clr_t2;
	logic [31:0] rd_word;

	assign rsp               = st.rsp;
	assign ctl               = st.ctl;
	assign ext0_flag         = st.ext0_request_flag;
	assign first_timer_flag  = st.first_timer_request_flag;
	assign second_timer_flag = st.second_timer_request_flag;
	assign wb_dat_o          = st.wb_dat;
	assign wb_ack_o          = st.wb_ack;
	assign bus_req           = wb_cyc_i && wb_stb_i;
	assign bus_wr            = bus_req && wb_we_i && st.wb_ack;

	// register read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		case (wb_adr_i)
			ADR_STATUS: begin
				rd_word[ST_GIE]  = st.ctl.global_irq_enable;
				rd_word[ST_EXT0] = st.ext0_request_flag;
				rd_word[ST_T1]   = st.first_timer_request_flag;
				rd_word[ST_T2]   = st.second_timer_request_flag;
				rd_word[ST_SKIP] = st.skip_pending;
			end
			ADR_IRQCTL: rd_word[11:0] = {st.ctl.ext_irq_control, st.ctl.irq_control_second,
				st.ctl.irq_control_first};
			ADR_TMRCTL: rd_word[11:0] = {st.ctl.timer_control_third, st.ctl.timer_control_second,
				st.ctl.timer_control_first};
			ADR_TIMER: rd_word = {st.ctl.second_timer_reload, st.ctl.second_timer_count,
				st.ctl.first_timer_reload, st.ctl.first_timer_count};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_st = st;
		clr_ext0 = 1'b0;
		clr_t1 = 1'b0;
		clr_t2 = 1'b0;
		next_st.rsp = '0;
		// bus slave: ack one cycle after request, write lands at the edge that ends the ack cycle
		next_st.wb_ack = bus_req && !st.wb_ack;
		if (bus_req && !st.wb_ack) begin
			next_st.wb_dat = rd_word;
		end
		if (bus_wr) begin
			case (wb_adr_i)
				ADR_STATUS: if (wb_sel_i[0]) begin
					next_st.ctl.global_irq_enable = wb_dat_i[ST_GIE];
					clr_ext0 = wb_dat_i[ST_EXT0];
					clr_t1 = wb_dat_i[ST_T1];
					clr_t2 = wb_dat_i[ST_T2];
				end
				ADR_IRQCTL: begin
					if (wb_sel_i[0]) begin
						next_st.ctl.irq_control_first = wb_dat_i[3:0];
						next_st.ctl.irq_control_second = wb_dat_i[7:4];
					end
					if (wb_sel_i[1]) begin
						next_st.ctl.ext_irq_control = wb_dat_i[11:8];
					end
				end
				ADR_TMRCTL: begin
					if (wb_sel_i[0]) begin
						next_st.ctl.timer_control_first = wb_dat_i[3:0];
						next_st.ctl.timer_control_second = wb_dat_i[7:4];
					end
					if (wb_sel_i[1]) begin
						next_st.ctl.timer_control_third = wb_dat_i[11:8];
					end
				end
				default: begin
				end
			endcase
		end
		// instruction execution, one response per request
		if (req.valid) begin
			next_st.rsp.done = 1'b1;
			if (st.skip_pending) begin
				next_st.rsp.suppressed = 1'b1;
				next_st.skip_pending = 1'b0;
			end else begin
				case (req.op)
					global_irq_off_op: next_st.ctl.global_irq_enable = 1'b0;
					global_irq_on_op: next_st.ctl.global_irq_enable = 1'b1;
					skip_on_ext0_op: begin
						if (!st.ctl.irq_control_first[EXT0_EN_BIT] && st.ext0_request_flag) begin
							next_st.rsp.skip = 1'b1;
							clr_ext0 = 1'b1;
						end
					end
					skip_on_pin_level_op: begin
						next_st.rsp.skip = (ext_pin == st.ctl.ext_irq_control[POL_BIT]);
					end
					read_irq_ctl_first_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.acc = st.ctl.irq_control_first;
					end
					write_irq_ctl_first_op: next_st.ctl.irq_control_first = req.acc;
					read_irq_ctl_second_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.acc = st.ctl.irq_control_second;
					end
					write_irq_ctl_second_op: next_st.ctl.irq_control_second = req.acc;
					read_ext_irq_ctl_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.acc = st.ctl.ext_irq_control;
					end
					write_ext_irq_ctl_op: next_st.ctl.ext_irq_control = req.acc;
					read_tmr_ctl_first_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.acc = st.ctl.timer_control_first;
					end
					write_tmr_ctl_first_op: next_st.ctl.timer_control_first = req.acc;
					read_tmr_ctl_second_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.acc = st.ctl.timer_control_second;
					end
					write_tmr_ctl_second_op: next_st.ctl.timer_control_second = req.acc;
					read_tmr_ctl_third_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.acc = st.ctl.timer_control_third;
					end
					write_tmr_ctl_third_op: next_st.ctl.timer_control_third = req.acc;
					read_first_timer_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.b_we = 1'b1;
						next_st.rsp.b = st.ctl.first_timer_count[7:NIB];
						next_st.rsp.acc = st.ctl.first_timer_count[NIB-1:0];
					end
					write_first_timer_op: begin
						next_st.ctl.first_timer_count = {req.b, req.acc};
						next_st.ctl.first_timer_reload = {req.b, req.acc};
					end
					read_second_timer_op: begin
						next_st.rsp.acc_we = 1'b1;
						next_st.rsp.b_we = 1'b1;
						next_st.rsp.b = st.ctl.second_timer_count[7:NIB];
						next_st.rsp.acc = st.ctl.second_timer_count[NIB-1:0];
					end
					write_second_timer_op: begin
						next_st.ctl.second_timer_count = {req.b, req.acc};
						next_st.ctl.second_timer_reload = {req.b, req.acc};
					end
					write_first_reload_op: next_st.ctl.first_timer_reload = {req.b, req.acc};
					skip_on_first_timer_op: begin
						if (!st.ctl.irq_control_first[T1_EN_BIT] && st.first_timer_request_flag) begin
							next_st.rsp.skip = 1'b1;
							clr_t1 = 1'b1;
						end
					end
					skip_on_second_timer_op: begin
						if (!st.ctl.irq_control_first[T2_EN_BIT] && st.second_timer_request_flag) begin
							next_st.rsp.skip = 1'b1;
							clr_t2 = 1'b1;
						end
					end
					default: begin
					end
				endcase
				next_st.skip_pending = next_st.rsp.skip;
			end
		end
		// request flags: a new event wins over any clear
		next_st.ext0_request_flag = (st.ext0_request_flag && !clr_ext0) || ext0_evt;
		next_st.first_timer_request_flag = (st.first_timer_request_flag && !clr_t1) || first_timer_evt;
		next_st.second_timer_request_flag = (st.second_timer_request_flag && !clr_t2) || second_timer_evt;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
			st.ctl.irq_control_first <= RST_NIB;
			st.ctl.first_timer_count <= RST_BYTE;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic go;
	assign go = req.valid && !st.skip_pending;

	gie_off_a: assert property (go && req.op == global_irq_off_op |=> !st.ctl.global_irq_enable)
		else $error("interrupt enable not cleared");
	gie_on_a: assert property (go && req.op == global_irq_on_op |=> st.ctl.global_irq_enable)
		else $error("interrupt enable not set");
	ext0_skip_a: assert property (go && req.op == skip_on_ext0_op && !st.ctl.irq_control_first[0]
		&& st.ext0_request_flag |=> st.rsp.skip && st.skip_pending
		&& st.ext0_request_flag == $past(ext0_evt))
		else $error("ext0 skip wrong");
	ext0_nop_a: assert property (go && req.op == skip_on_ext0_op && st.ctl.irq_control_first[0]
		&& st.ext0_request_flag |=> !st.rsp.skip && st.ext0_request_flag)
		else $error("ext0 nop touched flag");
	pin_skip_a: assert property (go && req.op == skip_on_pin_level_op
		|=> st.rsp.skip == ($past(ext_pin) == $past(st.ctl.ext_irq_control[2])))
		else $error("pin skip polarity wrong");
	read_ctl1_a: assert property (go && req.op == read_irq_ctl_first_op
		|=> st.rsp.acc_we && st.rsp.acc == $past(st.ctl.irq_control_first) && $stable(st.ctl))
		else $error("read of first control wrong");
	write_ctl1_a: assert property (go && req.op == write_irq_ctl_first_op
		|=> st.ctl.irq_control_first == $past(req.acc) && !st.rsp.acc_we)
		else $error("write of first control wrong");
	read_irq2_a: assert property (go && req.op == read_irq_ctl_second_op
		|=> st.rsp.acc_we && st.rsp.acc == $past(st.ctl.irq_control_second))
		else $error("read of second control wrong");
	write_irq2_a: assert property (go && req.op == write_irq_ctl_second_op
		|=> st.ctl.irq_control_second == $past(req.acc))
		else $error("write of second control wrong");
	read_ext_a: assert property (go && req.op == read_ext_irq_ctl_op
		|=> st.rsp.acc_we && st.rsp.acc == $past(st.ctl.ext_irq_control))
		else $error("read of external control wrong");
	write_ext_a: assert property (go && req.op == write_ext_irq_ctl_op
		|=> st.ctl.ext_irq_control == $past(req.acc))
		else $error("write of external control wrong");
	read_tctl1_a: assert property (go && req.op == read_tmr_ctl_first_op
		|=> st.rsp.acc_we && st.rsp.acc == $past(st.ctl.timer_control_first))
		else $error("read of timer control 1 wrong");
	write_tctl1_a: assert property (go && req.op == write_tmr_ctl_first_op
		|=> st.ctl.timer_control_first == $past(req.acc))
		else $error("write of timer control 1 wrong");
	read_tctl2_a: assert property (go && req.op == read_tmr_ctl_second_op
		|=> st.rsp.acc_we && st.rsp.acc == $past(st.ctl.timer_control_second))
		else $error("read of timer control 2 wrong");
	write_tctl2_a: assert property (go && req.op == write_tmr_ctl_second_op
		|=> st.ctl.timer_control_second == $past(req.acc))
		else $error("write of timer control 2 wrong");
	read_tctl3_a: assert property (go && req.op == read_tmr_ctl_third_op
		|=> st.rsp.acc_we && st.rsp.acc == $past(st.ctl.timer_control_third))
		else $error("read of timer control 3 wrong");
	write_tctl3_a: assert property (go && req.op == write_tmr_ctl_third_op
		|=> st.ctl.timer_control_third == $past(req.acc))
		else $error("write of timer control 3 wrong");
	write_tmr1_a: assert property (go && req.op == write_first_timer_op |=>
		st.ctl.first_timer_count == {$past(req.b), $past(req.acc)}
		&& st.ctl.first_timer_reload == {$past(req.b), $past(req.acc)})
		else $error("timer 1 write wrong");
	read_tmr2_a: assert property (go && req.op == read_second_timer_op
		|=> {st.rsp.b, st.rsp.acc} == $past(st.ctl.second_timer_count) && st.rsp.b_we && st.rsp.acc_we)
		else $error("timer 2 read wrong");
	t1_skip_a: assert property (go && req.op == skip_on_first_timer_op && !st.ctl.irq_control_first[2]
		&& st.first_timer_request_flag && !first_timer_evt
		|=> st.rsp.skip && st.skip_pending && !st.first_timer_request_flag)
		else $error("timer 1 skip wrong");
	t1_nop_a: assert property (go && req.op == skip_on_first_timer_op && st.ctl.irq_control_first[2]
		&& !bus_wr |=> !st.rsp.skip
		&& st.first_timer_request_flag == $past(st.first_timer_request_flag || first_timer_evt))
		else $error("timer 1 nop touched flag");
	bus_gie_a: assert property (bus_wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && !req.valid
		|=> st.ctl.global_irq_enable == $past(wb_dat_i[ST_GIE]))
		else $error("bus write of interrupt enable lost");
	read_tmr1_a: assert property (go && req.op == read_first_timer_op
		|=> {st.rsp.b, st.rsp.acc} == $past(st.ctl.first_timer_count) && st.rsp.b_we)
		else $error("timer 1 read wrong");
	write_tmr2_a: assert property (go && req.op == write_second_timer_op |=>
		st.ctl.second_timer_count == {$past(req.b), $past(req.acc)}
		&& st.ctl.second_timer_reload == st.ctl.second_timer_count)
		else $error("timer 2 write wrong");
	reload_only_a: assert property (go && req.op == write_first_reload_op |=>
		st.ctl.first_timer_reload == {$past(req.b), $past(req.acc)} && $stable(st.ctl.first_timer_count))
		else $error("reload write touched count");
	t2_skip_a: assert property (go && req.op == skip_on_second_timer_op && !st.ctl.irq_control_first[3]
		&& st.second_timer_request_flag && !second_timer_evt
		|=> st.rsp.skip && st.skip_pending && !st.second_timer_request_flag)
		else $error("timer 2 skip wrong");
	suppress_a: assert property (req.valid && st.skip_pending && !bus_wr |=> st.rsp.suppressed
		&& !st.rsp.acc_we && !st.rsp.b_we && !st.rsp.skip && $stable(st.ctl))
		else $error("skipped instruction had effect");
	wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack timing wrong");

	skip_taken_c: cover property (go && req.op == skip_on_first_timer_op ##1 st.rsp.skip ##1 st.rsp.suppressed);
	pin_skip_c: cover property (go && req.op == skip_on_pin_level_op ##1 st.rsp.skip);
	flag_race_c: cover property (st.rsp.skip && ext0_evt);
	bus_write_c: cover property (bus_wr && wb_adr_i == ADR_IRQCTL);
	bus_status_c: cover property (bus_wr && wb_adr_i == ADR_STATUS);
endmodule

/* itx_pkg.sv */
// package for the interrupt and timer instruction executor
package itx_pkg;
	localparam int         NIB          = 4;
	localparam int         EXT0_EN_BIT  = 0;
	localparam int         T1_EN_BIT    = 2;
	localparam int         T2_EN_BIT    = 3;
	localparam int         POL_BIT      = 2;
	localparam logic [7:0] ADR_STATUS   = 8'h00;
	localparam logic [7:0] ADR_IRQCTL   = 8'h04;
	localparam logic [7:0] ADR_TMRCTL   = 8'h08;
	localparam logic [7:0] ADR_TIMER    = 8'h0C;
	localparam int         ST_GIE       = 0;
	localparam int         ST_EXT0      = 1;
	localparam int         ST_T1        = 2;
	localparam int         ST_T2        = 3;
	localparam int         ST_SKIP      = 4;
	localparam logic [3:0] RST_NIB      = 4'h0;
	localparam logic [7:0] RST_BYTE     = 8'h00;

	typedef enum logic [4:0] {
		no_op,
		global_irq_off_op,
		global_irq_on_op,
		skip_on_ext0_op,
		skip_on_pin_level_op,
		read_irq_ctl_first_op,
		write_irq_ctl_first_op,
		read_irq_ctl_second_op,
		write_irq_ctl_second_op,
		read_ext_irq_ctl_op,
		write_ext_irq_ctl_op,
		read_tmr_ctl_first_op,
		write_tmr_ctl_first_op,
		read_tmr_ctl_second_op,
		write_tmr_ctl_second_op,
		read_tmr_ctl_third_op,
		write_tmr_ctl_third_op,
		read_first_timer_op,
		write_first_timer_op,
		read_second_timer_op,
		write_second_timer_op,
		write_first_reload_op,
		skip_on_first_timer_op,
		skip_on_second_timer_op
	} itx_op_t;

	typedef struct packed {
		logic       valid;
		itx_op_t    op;
		logic [3:0] acc;
		logic [3:0] b;
	} itx_req_t;

	typedef struct packed {
		logic       done;
		logic       suppressed;
		logic       skip;
		logic       acc_we;
		logic [3:0] acc;
		logic       b_we;
		logic [3:0] b;
	} itx_rsp_t;

	typedef struct packed {
		logic       global_irq_enable;
		logic [3:0] irq_control_first;
		logic [3:0] irq_control_second;
		logic [3:0] ext_irq_control;
		logic [3:0] timer_control_first;
		logic [3:0] timer_control_second;
		logic [3:0] timer_control_third;
		logic [7:0] first_timer_count;
		logic [7:0] first_timer_reload;
		logic [7:0] second_timer_count;
		logic [7:0] second_timer_reload;
	} itx_ctl_t;

	typedef struct packed {
		itx_rsp_t    rsp;
		itx_ctl_t    ctl;
		logic        ext0_request_flag;
		logic        first_timer_request_flag;
		logic        second_timer_request_flag;
		logic        skip_pending;
		logic        wb_ack;
		logic [31:0] wb_dat;
	} itx_state_t;
endpackage

/* itx_seq.sv */
// sequencer model issuing instructions and holding registers a and b
`timescale 1ns/1ps
module itx_seq (
	input  wire logic              ref_clk,
	output itx_pkg::itx_req_t      req,
	input  wire itx_pkg::itx_rsp_t rsp
);
	import itx_pkg::*;
	logic [3:0] reg_a;
	logic [3:0] reg_b;
	itx_rsp_t   last;
	initial begin
		req = '0;
		reg_a = 4'h0;
		reg_b = 4'h0;
		last = '0;
	end
	// one instruction, answer taken at the edge after acceptance
	task automatic exec(input itx_op_t op, input logic [3:0] a, input logic [3:0] b);
		req <= '{valid: 1'b1, op: op, acc: a, b: b};
		@(posedge ref_clk);
		req <= '0;
		@(posedge ref_clk);
		last = rsp;
		if (rsp.acc_we === 1'b1) reg_a = rsp.acc;
		if (rsp.b_we === 1'b1) reg_b = rsp.b;
	endtask
endmodule

/* tb.sv */
// self-checking bench for the interrupt and timer instruction executor
`timescale 1ns/1ps
module tb;
	import itx_pkg::*;
	logic        ref_clk;
	logic        rst;
	itx_req_t    req;
	itx_rsp_t    rsp;
	itx_ctl_t    ctl;
	wire  [2:0]  flag_vec;
	logic        ext_pin;
	logic [2:0]  evt;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	itx_rsp_t    r;
	int          mismatches;
	int          samples_checked;
	wire  [23:0] fields = {ctl.timer_control_third, ctl.timer_control_second, ctl.timer_control_first,
		ctl.ext_irq_control, ctl.irq_control_second, ctl.irq_control_first};
	itx_op_t     wr_op [6] = '{write_irq_ctl_first_op, write_irq_ctl_second_op, write_ext_irq_ctl_op,
		write_tmr_ctl_first_op, write_tmr_ctl_second_op, write_tmr_ctl_third_op};
	itx_op_t     rd_op [6] = '{read_irq_ctl_first_op, read_irq_ctl_second_op, read_ext_irq_ctl_op,
		read_tmr_ctl_first_op, read_tmr_ctl_second_op, read_tmr_ctl_third_op};
	itx_op_t     sk_op [3] = '{skip_on_ext0_op, skip_on_first_timer_op, skip_on_second_timer_op};
	int          en_bit [3] = '{EXT0_EN_BIT, T1_EN_BIT, T2_EN_BIT};

	itx_exec itx_exec_i (.ref_clk, .rst, .req, .rsp, .ctl, .ext0_flag(flag_vec[0]),
		.first_timer_flag(flag_vec[1]), .second_timer_flag(flag_vec[2]), .ext_pin,
		.ext0_evt(evt[0]), .first_timer_evt(evt[1]), .second_timer_evt(evt[2]), .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
	itx_seq itx_seq_i (.ref_clk, .req, .rsp);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic run(input itx_op_t op, input logic [3:0] a, input logic [3:0] b);
		itx_seq_i.exec(op, a, b);
		r = itx_seq_i.last;
	endtask

	task automatic pulse(input int k);
		evt[k] <= 1'b1;
		@(posedge ref_clk);
		evt[k] <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// let the write land before anyone looks
		@(posedge ref_clk);
	endtask

	task automatic t_gie;
		run(global_irq_on_op, 4'h0, 4'h0);
		chk(ctl.global_irq_enable, 1);
		run(global_irq_off_op, 4'h0, 4'h0);
		chk(ctl.global_irq_enable, 0);
	endtask

	task automatic t_ctl;
		logic [3:0] v;
		for (int i = 0; i < 6; i++) begin
			v = 4'(i + 9);
			run(wr_op[i], v, 4'h0);
			chk(fields[i*4 +: 4], v);
			run(rd_op[i], 4'h0, 4'h0);
			chk({r.acc_we, r.acc, fields[i*4 +: 4]}, {1'b1, v, v});
		end
	endtask

	task automatic t_tmr;
		run(write_first_timer_op, 4'hC, 4'h3);
		chk({ctl.first_timer_count, ctl.first_timer_reload}, 16'h3C3C);
		run(read_first_timer_op, 4'h0, 4'h0);
		chk({r.b_we, r.acc_we, r.b, r.acc}, 10'h33C);
		run(write_first_reload_op, 4'h1, 4'h9);
		chk({ctl.first_timer_count, ctl.first_timer_reload}, 16'h3C91);
		run(write_second_timer_op, 4'h7, 4'hE);
		chk({ctl.second_timer_count, ctl.second_timer_reload}, 16'hE7E7);
		run(read_second_timer_op, 4'h0, 4'h0);
		chk({r.b_we, r.acc_we, r.b, r.acc}, 10'h3E7);
	endtask

	task automatic t_flag(input int k);
		run(write_irq_ctl_first_op, 4'h0, 4'h0);
		pulse(k);
		run(sk_op[k], 4'h0, 4'h0);
		chk({r.skip, r.suppressed, flag_vec[k]}, 3'h4);
		run(write_irq_ctl_second_op, 4'hF, 4'h0);
		chk({r.suppressed, r.skip, r.done, ctl.irq_control_second}, 7'h5A);
		run(sk_op[k], 4'h0, 4'h0);
		chk(r.skip, 0);
		run(write_irq_ctl_first_op, 4'(1 << en_bit[k]), 4'h0);
		pulse(k);
		run(sk_op[k], 4'h0, 4'h0);
		chk({r.skip, flag_vec[k]}, 2'h1);
		run(write_irq_ctl_first_op, 4'h0, 4'h0);
		run(sk_op[k], 4'h0, 4'h0);
		run(no_op, 4'h0, 4'h0);
	endtask

	task automatic t_pin;
		for (int p = 0; p < 2; p++) begin
			for (int q = 0; q < 2; q++) begin
				run(write_ext_irq_ctl_op, 4'(p << POL_BIT), 4'h0);
				ext_pin <= q[0];
				run(skip_on_pin_level_op, 4'h0, 4'h0);
				chk(r.skip, p == q);
				run(no_op, 4'h0, 4'h0);
				chk(r.suppressed, p == q);
			end
		end
	endtask

	task automatic t_bus;
		logic [31:0] q;
		wb(1'b1, ADR_IRQCTL, 32'h0000_0321, q);
		chk(fields[11:0], 12'h321);
		wb(1'b0, ADR_IRQCTL, 32'h0, q);
		chk(q[11:0], 12'h321);
		wb(1'b0, ADR_TIMER, 32'h0, q);
		chk(q, 32'hE7E7_913C);
		wb(1'b1, 8'h10, 32'hFFFF_FFFF, q);
		wb(1'b0, 8'h10, 32'h0, q);
		chk(q, 32'h0);
		pulse(0);
		wb(1'b1, ADR_STATUS, 32'h0000_0001, q);
		wb(1'b0, ADR_STATUS, 32'h0, q);
		chk(q, 32'h0000_0003);
		wb(1'b1, ADR_STATUS, 32'h0000_0003, q);
		chk({ctl.global_irq_enable, flag_vec}, 4'h8);
	endtask

	initial begin
		repeat (4000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end

	initial begin
		mismatches = 0;
		samples_checked = 0;
		rst = 1'b1;
		ext_pin = 1'b0;
		evt = 3'h0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk({ctl.global_irq_enable, fields, flag_vec}, 32'h0);
		chk({rsp, wb_ack_o}, 32'h0);
		chk(wb_dat_o, 32'h0);
		t_gie();
		t_ctl();
		t_tmr();
		for (int k = 0; k < 3; k++) t_flag(k);
		t_pin();
		t_bus();
		conclude();
	end
endmodule
